// *** rtl/wdt_regs.vh ***
/*
 Register offsets, field positions, reset values, keys and timing counts
 of the watchdog / interval timer. Assumes inclusion once per unit.
*/
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// ==========================================
// Addresses (lower 16 bits)
`define WDT_ADDR_CTRL_WR   16'hFFBC
`define WDT_ADDR_CTRL_RD   16'hFFBC
`define WDT_ADDR_COUNT_RD  16'hFFBD
`define WDT_ADDR_RST_WR    16'hFFBE
`define WDT_ADDR_RST_RD    16'hFFBF
// ==========================================
// Write keys
`define WDT_KEY_COUNT      8'h5A
`define WDT_KEY_CTRL       8'hA5
`define WDT_KEY_RST_FLAG   8'hA5
`define WDT_KEY_RST_CFG    8'h5A
// ==========================================
// Fields and reset values
`define WDT_BIT_FLAG       7
`define WDT_BIT_MODE       6
`define WDT_BIT_RUN        5
`define WDT_BIT_CHIP_RESET_ON_OVERFLOW       6
`define WDT_BIT_RESET_TYPE_SELECT       5
`define WDT_CTRL_RESET     8'h18
`define WDT_RST_RESET      8'h1F
`define WDT_COUNT_RESET    8'h00
// ==========================================
// Timing in system clock states
`define WDT_PIN_STATES_RST   132
`define WDT_PIN_STATES_NORST 130
`define WDT_IRST_STATES      518
`endif

// *** rtl/wdt_timer.v ***
/*
 Watchdog / interval timer: 8-bit counter on a prescaled tap, keyed word
 writes, overflow pin, interval request and internal reset request.
 Assumes a CPU bus with one-cycle read/write strobes and a word flag; the
 reset and interrupt controllers act on the request outputs outside.
*/
// Function
// - Counter advances on selected tap while running
// - Wrap drives pin or interval request
// - Counter zero on reset, standby, stop
// - Control register 0x18 on reset, standby
// - Interval flag set only in interval mode
// - Interval flag cleared by read-then-write-zero
// - Mode bit chooses request or pin
// - Run bit halts and zeroes counter
// - Reserved bits read one, writes ignored
// - Select decodes eight divide taps
// - Reset control init only by pin reset
// - Watchdog flag set only in watchdog mode
// - Watchdog flag cleared by read-then-write-zero
// - Chip reset enable; local reset on every watchdog-mode overflow
// - Reset type power-on or manual
// - Count/control accept word writes only
// - High byte key picks count or control
// - Reset control accepts word writes only
// - Key A5 with 00 clears watchdog flag
// - Key 5A writes reset enable, type
// - Pin low 132 or 130 states
// - Internal reset held 518 states
`include "wdt_regs.vh"
`default_nettype none
module wdt_timer
(
   input wire mclk,
   input wire rst_n,
   input wire hw_standby,
   input wire [15:0] bus_addr,
   input wire [15:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   input wire bus_word,
   output reg [7:0] bus_rdata,
   output reg overflow_pin_n,
   output reg interval_irq,
   output reg chip_reset_req,
   output reg chip_reset_manual
);
   // ==========================================
   // State
   reg [7:0] count_reg;
   reg flag_reg;
   reg mode_reg;
   reg run_reg;
   reg [2:0] sel_reg;
   reg wflag_reg;
   reg chip_reset_on_overflow_reg;
   reg reset_type_select_reg;
   reg flag_seen_reg;
   reg wflag_seen_reg;
   reg [16:0] pre_reg;
   reg [8:0] pin_cnt_reg;
   reg [9:0] irst_cnt_reg;
   reg local_rst_reg;
   wire standby_clr;
   wire tick;
   wire wrap;
   wire pin_busy;
   wire wr_ctl;
   wire wr_rst;
   wire [7:0] ctrl_view;
   wire [7:0] rst_view;
   wire [1:0] pin_raw;
   wire [1:0] pin_flt;
   wire pin_rst_n;
   wire pin_standby;
   genvar gi;

   // Selected prescaler tap mask; a tick fires when masked bits are all one
   // divide tap decode
   function [16:0] tap_mask;
      input [2:0] s;
      begin
         case (s)
            3'h0: tap_mask = 17'h00001;
            3'h1: tap_mask = 17'h0003F;
            3'h2: tap_mask = 17'h0007F;
            3'h3: tap_mask = 17'h001FF;
            3'h4: tap_mask = 17'h007FF;
            3'h5: tap_mask = 17'h01FFF;
            3'h6: tap_mask = 17'h07FFF;
            default: tap_mask = 17'h1FFFF;
         endcase
      end
   endfunction

   // ==========================================
   // Pin synchronisers: a level counts once the last two flops agree
   assign pin_raw = {hw_standby, rst_n};
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_pin_sync
         reg sync1_reg;
         reg sync2_reg;
         reg sync3_reg;
         reg flt_reg;
         // Costs four to five cycles before reset or standby acts
         always @(posedge mclk)
         begin
            sync1_reg <= pin_raw[gi];
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg)
               flt_reg <= sync3_reg;
         end
         assign pin_flt[gi] = flt_reg;
      end
   endgenerate
   assign pin_rst_n = pin_flt[0];
   assign pin_standby = pin_flt[1];

   assign standby_clr = ~pin_rst_n | pin_standby;
   assign tick = run_reg & ((pre_reg & tap_mask(sel_reg)) == tap_mask(sel_reg));
   assign wrap = tick & (count_reg == 8'hFF);
   // Writes are locked out while the pin is low
   assign pin_busy = ~overflow_pin_n;
   assign wr_ctl = bus_wr & bus_word & ~pin_busy & (bus_addr == `WDT_ADDR_CTRL_WR);
   assign wr_rst = bus_wr & bus_word & ~pin_busy & (bus_addr == `WDT_ADDR_RST_WR);
   assign ctrl_view = {flag_reg, mode_reg, run_reg, 2'b11, sel_reg};
   assign rst_view = {wflag_reg, chip_reset_on_overflow_reg, reset_type_select_reg, 5'h1F};

   // ==========================================
   // Prescaler: free runs, cleared while halted so the first tap is full
   always @(posedge mclk)
   begin
      if (standby_clr | ~run_reg)
         pre_reg <= 17'h00000;
      else
         pre_reg <= pre_reg + 17'h00001;
   end

   // ==========================================
   // Counter and control register
   always @(posedge mclk)
   begin
      if (standby_clr | local_rst_reg)
      begin
         count_reg <= `WDT_COUNT_RESET;
         flag_reg <= 1'b0;
         mode_reg <= 1'b0;
         run_reg <= 1'b0;
         sel_reg <= 3'h0;
         flag_seen_reg <= 1'b0;
      end
      else
      begin
         // Read of flag at one arms the clear
         if (bus_rd & (bus_addr == `WDT_ADDR_CTRL_RD) & flag_reg)
            flag_seen_reg <= 1'b1;
         // keyed count write, wins over increment
         if (wr_ctl & (bus_wdata[15:8] == `WDT_KEY_COUNT))
            count_reg <= bus_wdata[7:0];
         else if (~run_reg)
            count_reg <= 8'h00;
         else if (tick)
            count_reg <= count_reg + 8'h01;
         if (wr_ctl & (bus_wdata[15:8] == `WDT_KEY_CTRL))
         begin
            mode_reg <= bus_wdata[`WDT_BIT_MODE];
            run_reg <= bus_wdata[`WDT_BIT_RUN];
            sel_reg <= bus_wdata[2:0];
         end
         // set in interval mode only, set beats clear
         if (wrap & ~mode_reg)
         begin
            flag_reg <= 1'b1;
            // A set that meets a pending clear needs a fresh read
            flag_seen_reg <= 1'b0;
         end
         // clear after read, writing one has no effect
         else if (wr_ctl & (bus_wdata[15:8] == `WDT_KEY_CTRL) & ~bus_wdata[`WDT_BIT_FLAG] & flag_seen_reg)
         begin
            flag_reg <= 1'b0;
            flag_seen_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // Reset control register: only the external reset initialises it
   always @(posedge mclk)
   begin
      if (~pin_rst_n)
      begin
         wflag_reg <= 1'b0;
         chip_reset_on_overflow_reg <= 1'b0;
         reset_type_select_reg <= 1'b0;
         wflag_seen_reg <= 1'b0;
      end
      else
      begin
         // Reads are not recognised while the pin is low
         if (bus_rd & ~pin_busy & (bus_addr == `WDT_ADDR_RST_RD) & wflag_reg)
            wflag_seen_reg <= 1'b1;
         if (wr_rst & (bus_wdata[15:8] == `WDT_KEY_RST_CFG))
         begin
            chip_reset_on_overflow_reg <= bus_wdata[`WDT_BIT_CHIP_RESET_ON_OVERFLOW];
            reset_type_select_reg <= bus_wdata[`WDT_BIT_RESET_TYPE_SELECT];
         end
         if (wrap & mode_reg)
         begin
            wflag_reg <= 1'b1;
            // A set that meets a pending clear needs a fresh read
            wflag_seen_reg <= 1'b0;
         end
         else if (wr_rst & (bus_wdata == {`WDT_KEY_RST_FLAG, 8'h00}) & wflag_seen_reg)
         begin
            wflag_reg <= 1'b0;
            wflag_seen_reg <= 1'b0;
         end
      end
   end

   // ==========================================
   // Overflow pin and internal reset timing
   always @(posedge mclk)
   begin
      if (standby_clr)
      begin
         pin_cnt_reg <= 9'h000;
         irst_cnt_reg <= 10'h000;
         overflow_pin_n <= 1'b1;
         chip_reset_req <= 1'b0;
         chip_reset_manual <= 1'b0;
         local_rst_reg <= 1'b0;
      end
      else
      begin
         local_rst_reg <= 1'b0;
         if (wrap & mode_reg)
         begin
            overflow_pin_n <= 1'b0;
            pin_cnt_reg <= chip_reset_on_overflow_reg ? 9'd`WDT_PIN_STATES_RST - 9'd1 : 9'd`WDT_PIN_STATES_NORST - 9'd1;
            // counter and control clear on every overflow
            // as the chip reset covers them too
            local_rst_reg <= 1'b1;
            if (chip_reset_on_overflow_reg)
            begin
               chip_reset_req <= 1'b1;
               chip_reset_manual <= reset_type_select_reg;
               irst_cnt_reg <= 10'd`WDT_IRST_STATES - 10'd1;
            end
         end
         else
         begin
            if (pin_cnt_reg != 9'h000)
               pin_cnt_reg <= pin_cnt_reg - 9'h001;
            else
               overflow_pin_n <= 1'b1;
            if (irst_cnt_reg != 10'h000)
               irst_cnt_reg <= irst_cnt_reg - 10'h001;
            else
               chip_reset_req <= 1'b0;
         end
      end
   end

   // ==========================================
   // Interval request follows the flag; read data registered
   always @(posedge mclk)
   begin
      if (~pin_rst_n)
      begin
         interval_irq <= 1'b0;
         bus_rdata <= 8'h00;
      end
      else
      begin
         interval_irq <= flag_reg & ~pin_standby;
         if (bus_rd)
         begin
            case (bus_addr)
               `WDT_ADDR_CTRL_RD: bus_rdata <= ctrl_view;
               `WDT_ADDR_COUNT_RD: bus_rdata <= count_reg;
               `WDT_ADDR_RST_RD: bus_rdata <= rst_view;
               default: bus_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // wdt_timer
`default_nettype wire

// *** tb/test_watchdog_interval_timer.sv ***
/* Self-checking bench for the watchdog / interval timer.
   Assumes the CPU model drives the bus and the checker is bound. */
`default_nettype none
// ==========
// Bench
module test_watchdog_interval_timer;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, rst_n, hw_standby, bus_wr, bus_rd, bus_word;
   logic overflow_pin_n, interval_irq, chip_reset_req, chip_reset_manual;
   logic [15:0] bus_addr, bus_wdata;
   logic [7:0] bus_rdata, q;
   int fails, samples_checked, n;
   int dv[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};
   // 25 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   wdt_timer i_wdt_timer (.mclk, .rst_n, .hw_standby, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_word,
      .bus_rdata, .overflow_pin_n, .interval_irq, .chip_reset_req, .chip_reset_manual);
   wdt_cpu_model i_wdt_cpu_model (.mclk, .bus_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_word);
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      if (fails == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Bounded wait while a signal keeps a level
   task automatic span(ref logic s, input logic v, input int lim);
      while (s === v && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         fails++;
         close_out();
      end
   endtask
   task automatic w(input logic [15:0] a, input logic [15:0] d, input logic wd);
      i_wdt_cpu_model.wr(a, d, wd);
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
      i_wdt_cpu_model.rd(a, q);
      chk(nm, e, q);
   endtask
   task automatic t_keys;
      rc(16'hFFBC, 8'h18, "ctrl");
      rc(16'hFFBF, 8'h1F, "rstc");
      w(16'hFFBC, 16'hA527, 1'b0);
      w(16'hFFBC, 16'h3327, 1'b1);
      w(16'hFFBE, 16'h5A60, 1'b0);
      w(16'hFFBC, 16'h5A44, 1'b1);
      rc(16'hFFBC, 8'h18, "ctrl");
      rc(16'hFFBD, 8'h00, "count");
      rc(16'hFFBF, 8'h1F, "rstc");
   endtask
   task automatic t_interval;
      w(16'hFFBC, 16'hA520, 1'b1);
      w(16'hFFBC, 16'h5AF8, 1'b1);
      n = 0;
      span(interval_irq, 1'b0, 100);
      chk("pin", 1'b1, overflow_pin_n);
      rc(16'hFFBC, 8'hB8, "ctrl");
      rc(16'hFFBC, 8'hB8, "ctrl");
      w(16'hFFBC, 16'hA5B8, 1'b1);
      rc(16'hFFBC, 8'hB8, "ctrl");
      w(16'hFFBC, 16'hA538, 1'b1);
      repeat (2) @(posedge mclk);
      #1;
      chk("irq", 1'b0, interval_irq);
      // Standby must outlast the pin filter, then settle before reads
      hw_standby <= 1'b1;
      repeat (3) @(posedge mclk);
      hw_standby <= 1'b0;
      repeat (4) @(posedge mclk);
      rc(16'hFFBC, 8'h18, "ctrl");
      rc(16'hFFBD, 8'h00, "count");
   endtask
   task automatic t_div;
      for (int k = 1; k < 8; k++)
      begin
         w(16'hFFBC, 16'hA500, 1'b1);
         w(16'hFFBC, 16'hA520 | 16'(k), 1'b1);
         // Slow taps: no tick may come before half of the smallest of them
         repeat ((k < 5) ? 4 * dv[k] : 4100) @(posedge mclk);
         i_wdt_cpu_model.rd(16'hFFBD, q);
         if (k < 5)
            chk("ticks", 1'b1, q >= 8'd3 && q <= 8'd5);
         else
            chk("slow ticks", 8'h00, q);
      end
   endtask
   task automatic t_wdog(input logic [7:0] cfg, input int plen, input int rlen);
      w(16'hFFBE, {8'h5A, cfg}, 1'b1);
      w(16'hFFBC, 16'hA500, 1'b1);
      w(16'hFFBC, 16'hA561, 1'b1);
      w(16'hFFBC, 16'h5AFF, 1'b1);
      n = 0;
      span(overflow_pin_n, 1'b1, 200);
      n = 0;
      span(overflow_pin_n, 1'b0, 200);
      chk("plen", plen, n);
      chk("rtype", {cfg[6], cfg[6] & cfg[5]}, {chip_reset_req, chip_reset_req & chip_reset_manual});
      span(chip_reset_req, 1'b1, 600);
      chk("rlen", rlen, n);
      w(16'hFFBE, 16'hA500, 1'b1);
      rc(16'hFFBF, {1'b1, cfg[6:5], 5'h1F}, "rstc");
      w(16'hFFBE, 16'hA500, 1'b1);
      rc(16'hFFBF, {1'b0, cfg[6:5], 5'h1F}, "rstc");
      rc(16'hFFBC, 8'h18, "ctrl");
      w(16'hFFBC, 16'hA500, 1'b1);
   endtask
   // Main sequence
   initial
   begin
      fails = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      hw_standby = 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // The reset pin is filtered, so the block leaves reset a few cycles late
      repeat (5) @(posedge mclk);
      t_keys();
      t_interval();
      t_div();
      t_wdog(8'h60, 132, 518);
      t_wdog(8'h40, 132, 518);
      t_wdog(8'h00, 130, 130);
      close_out();
   end
endmodule // test_watchdog_interval_timer
`default_nettype wire

// *** tb/wdt_cpu_model.sv ***
/* CPU model: keyed word writes and reads on the timer's register bus.
   Assumes one-cycle strobes taken at a rising edge of mclk. */
`default_nettype none
// ==========
// CPU side
module wdt_cpu_model
(
   input wire logic mclk,
   input wire logic [7:0] bus_rdata,
   output logic [15:0] bus_addr,
   output logic [15:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero
   initial
   begin
      bus_addr = 16'h0000;
      bus_wdata = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_word = 1'b0;
   end
   // word writes, byte only when asked
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      @(posedge mclk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_word <= w;
      bus_wr <= 1'b1;
      @(posedge mclk);
      bus_wr <= 1'b0;
      bus_addr <= ~a; // Released lines show no stale value
      bus_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      @(posedge mclk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge mclk);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      #1;
      q = bus_rdata;
   endtask
endmodule // wdt_cpu_model
`default_nettype wire

// *** tb/wdt_timer_properties.sv ***
/* Port checker for the timer.
   Assumes a bind into every wdt_timer. */
`default_nettype none
// ==========
// Checker
module wdt_chk
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hw_standby,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic overflow_pin_n,
   input wire logic interval_irq,
   input wire logic chip_reset_req
);
   timeunit 1ns;
   timeprecision 1ns;
   // All checks on mclk, muted in reset
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   rst_out_a: assert property ($rose(rst_n) |->
      bus_rdata == 8'h00 && overflow_pin_n && !interval_irq && !chip_reset_req) else $error("bad reset outputs");
   ctrl_rsvd_a: assert property (bus_rd && bus_addr == 16'hFFBC |=> bus_rdata[4:3] == 2'b11)
      else $error("ctrl reserved bits");
   rstc_rsvd_a: assert property (bus_rd && bus_addr == 16'hFFBF && overflow_pin_n |=> bus_rdata[4:0] == 5'h1F)
      else $error("reset ctrl reserved bits");
   pin_short_a: assert property ($fell(overflow_pin_n) |->
      ##129 !overflow_pin_n ##1 (overflow_pin_n != chip_reset_req)) else $error("pin low length");
   pin_long_a: assert property ($fell(overflow_pin_n) ##131 (chip_reset_req && !overflow_pin_n) |=> overflow_pin_n)
      else $error("pin low too long");
   ireq_len_a: assert property ($rose(chip_reset_req) |->
      ##300 1'b1 ##217 chip_reset_req ##1 !chip_reset_req) else $error("reset request length");
   ireq_src_a: assert property ($rose(chip_reset_req) |-> ##[0:1] !overflow_pin_n)
      else $error("reset request without pin");
   irq_fall_a: assert property ($fell(interval_irq) |->
      $past(bus_wr, 2) || $past(hw_standby, 5) || !$past(overflow_pin_n, 2) || !$past(rst_n, 5)) else $error("irq lost");
   cover property ($rose(interval_irq));
   cover property ($rose(chip_reset_req));
   cover property ($fell(overflow_pin_n) && !chip_reset_req);
endmodule // wdt_chk
bind wdt_timer wdt_chk i_wdt_chk (.mclk, .rst_n, .hw_standby, .bus_addr, .bus_wr, .bus_rd, .bus_rdata,
   .overflow_pin_n, .interval_irq, .chip_reset_req);
`default_nettype wire
